// *** cfdfs_asserts.sv ***
// concurrent checks on the fifo status block ports
`timescale 1ns/1ps
module cfdfs_asserts
   import cfdfs_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [DATA_W-1:0] RDATA,
   input wire logic MSG_PUSH,
   input wire logic MSG_POP,
   input wire logic TX_DONE,
   input wire logic TX_ABORTED,
   input wire logic TX_LOST_ARB,
   input wire logic TX_BUS_ERR,
   input wire logic TX_ATTEMPTS_OUT,
   input wire logic EVT_PUSH,
   input wire logic EVT_STORE_STAMP,
   input wire logic SEND_REQUEST,
   input wire logic MSG_IRQ,
   input wire logic EVT_IRQ
);
   logic tsen_r;
   logic dir_r;
   logic [4:0] mie_r;
   logic [3:0] eie_r;
   // shadow of the control bits the checks depend on
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         tsen_r <= 1'b0;
         eie_r <= 4'h0;
         dir_r <= 1'b0;
         mie_r <= 5'h00;
      end else if (WR && ADDR == OFF_EVT_CTRL_LOW) begin
         tsen_r <= WDATA[B_TSEN];
         eie_r <= WDATA[3:0];
      end else if (WR && ADDR == OFF_MSG_CTRL) begin
         dir_r <= WDATA[B_DIR];
         mie_r <= WDATA[4:0];
      end
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   sequence st_rd;
      RD && ADDR == OFF_MSG_STATUS && !TX_DONE;
   endsequence
   sequence gap_rd;
      (!TX_DONE && !WR && !RD) ##1 st_rd;
   endsequence
   a_stamp_gate: assert property (
      EVT_STORE_STAMP == (EVT_PUSH && tsen_r)) else $error("stamp bad");
   a_abort_read: assert property (
      st_rd ##1 gap_rd |=> !RDATA[B_ABORT]) else $error("abort kept");
   a_send_clears: assert property (
      (WR && ADDR == OFF_MSG_CTRL && WDATA[B_SEND] && dir_r
      && !SEND_REQUEST && !TX_DONE) ##1 gap_rd |=> RDATA[7:5] == 3'h0)
      else $error("send kept outcome");
   a_write_clears: assert property (
      (WR && ADDR == OFF_MSG_STATUS && !TX_DONE) ##1 gap_rd
      |=> RDATA[7:5] == 3'h0) else $error("write kept outcome");
   a_outcome_cap: assert property (
      (TX_DONE && TX_ABORTED && TX_LOST_ARB && TX_BUS_ERR && dir_r && !WR
      && !$past(WR)) ##1 gap_rd |=> RDATA[7:5] == 3'h7)
      else $error("outcome lost");
   a_evt_nonempty: assert property (
      EVT_PUSH && !WR && !$past(WR) && eie_r[0] |=> EVT_IRQ)
      else $error("event irq missing");
   a_rx_nonempty: assert property (
      MSG_PUSH && !MSG_POP && !WR && !$past(WR) && !dir_r && mie_r[0]
      |=> MSG_IRQ) else $error("msg irq missing");
   a_msg_masked: assert property (
      mie_r == 5'h00 |-> !MSG_IRQ) else $error("msg irq unmasked");
   a_evt_masked: assert property (
      eie_r == 4'h0 |-> !EVT_IRQ) else $error("event irq unmasked");
endmodule
bind cfdfs_top cfdfs_asserts i_cfdfs_asserts (
   .CLOCK (CLOCK),
   .RESETN (RESETN),
   .ADDR (ADDR),
   .WDATA (WDATA),
   .WR (WR),
   .RD (RD),
   .RDATA (RDATA),
   .MSG_PUSH (MSG_PUSH),
   .MSG_POP (MSG_POP),
   .TX_DONE (TX_DONE),
   .TX_ABORTED (TX_ABORTED),
   .TX_LOST_ARB (TX_LOST_ARB),
   .TX_BUS_ERR (TX_BUS_ERR),
   .TX_ATTEMPTS_OUT (TX_ATTEMPTS_OUT),
   .EVT_PUSH (EVT_PUSH),
   .EVT_STORE_STAMP (EVT_STORE_STAMP),
   .SEND_REQUEST (SEND_REQUEST),
   .MSG_IRQ (MSG_IRQ),
   .EVT_IRQ (EVT_IRQ)
);

// *** cfdfs_level.sv ***
// fill level decoder: full, empty and half thresholds
`timescale 1ns/1ps
module cfdfs_level
   import cfdfs_pkg::*;
(
   cfdfs_lvl_if.dec lvl
);
   logic [5:0] depth;
   always_comb begin
      depth = {1'b0, lvl.depth_code} + 6'h01;
      lvl.full = (lvl.count >= depth);
      lvl.empty = (lvl.count == 6'h00);
      lvl.half_up = ({lvl.count, 1'b0} >= {1'b0, depth});
      lvl.half_down = ({lvl.count, 1'b0} <= {1'b0, depth});
   end
endmodule

// *** cfdfs_lvl_if.sv ***
// interface carrying one fifo's depth and fill level to its flag logic
`timescale 1ns/1ps
interface cfdfs_lvl_if;
   logic [4:0] depth_code;
   logic [5:0] count;
   logic full;
   logic empty;
   logic half_up;
   logic half_down;
   modport src (output depth_code, output count,
      input full, input empty, input half_up, input half_down);
   modport dec (input depth_code, input count,
      output full, output empty, output half_up, output half_down);
endinterface

// *** cfdfs_pkg.sv ***
// package of register map, field positions and reset values
package cfdfs_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned CNT_W = 6;
   localparam logic [3:0] OFF_MSG_CTRL = 4'h0;
   localparam logic [3:0] OFF_MSG_STATUS = 4'h1;
   localparam logic [3:0] OFF_MSG_SIZE = 4'h2;
   localparam logic [3:0] OFF_EVT_CTRL_HIGH = 4'h3;
   localparam logic [3:0] OFF_EVT_CTRL_LOW = 4'h4;
   localparam logic [3:0] OFF_EVT_STATUS = 4'h5;
   localparam logic [3:0] OFF_MODE = 4'h6;
   localparam logic [3:0] OFF_EVT_LEVEL = 4'h7;
   localparam int unsigned B_DIR = 7;
   localparam int unsigned B_ABORT = 7;
   localparam int unsigned B_LARB = 6;
   localparam int unsigned B_BERR = 5;
   localparam int unsigned B_ATTEMPT = 4;
   localparam int unsigned B_OVF = 3;
   localparam int unsigned B_EF = 2;
   localparam int unsigned B_HALF = 1;
   localparam int unsigned B_NFNE = 0;
   localparam int unsigned B_TSEN = 5;
   localparam int unsigned B_CLEAR = 10;
   localparam int unsigned B_SEND = 9;
   localparam int unsigned B_ADV = 8;
   localparam int unsigned B_SIZE_LO = 8;
   localparam int unsigned B_MODE_LO = 0;
   localparam logic [2:0] MODE_CONFIG = 3'h4;
   localparam logic [2:0] MODE_RESET = 3'h4;
   localparam logic [4:0] SIZE_RESET = 5'h00;
   localparam logic [7:0] MSG_CTRL_RESET = 8'h00;
   localparam logic [3:0] EVT_IE_RESET = 4'h0;
endpackage

// *** cfdfs_top.sv ***
// fifo status, index and flag logic of a message fifo and event fifo
// Operation
// - direction bit one transmits, zero receives
// - enable bit 2 gates empty/full
// - enable bit 1 gates half level
// - enable bit 0 gates notfull/notempty
// - index shows next transmit or fill slot
// - index zero based, below configured depth
// - outcome bits update on completion or reset
// - abort cleared by read; all by request/write
// - attempts flag hardware set, tx only
// - overflow flag hardware set, rx only
// - bit 2: tx empty or rx full
// - bit 1: tx at most half, rx at least
// - bit 0: tx free slot, rx nonempty
// - event depth is size code plus one
// - event clear bit resets, hardware clears
// - tail advance bit pops exactly one
// - timestamp stored only when enabled
// - four event enables gate matching flags
// - event overflow set by hardware, software clears
// - event level flags are live
`timescale 1ns/1ps
module cfdfs_top
   import cfdfs_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [DATA_W-1:0] RDATA,
   input wire logic MSG_PUSH,
   input wire logic MSG_POP,
   input wire logic TX_DONE,
   input wire logic TX_ABORTED,
   input wire logic TX_LOST_ARB,
   input wire logic TX_BUS_ERR,
   input wire logic TX_ATTEMPTS_OUT,
   input wire logic EVT_PUSH,
   output logic EVT_STORE_STAMP,
   output logic SEND_REQUEST,
   output logic MSG_IRQ,
   output logic EVT_IRQ
);
   cfdfs_lvl_if msg_lvl();
   cfdfs_lvl_if evt_lvl();

   logic [7:0] ctrl_r, ctrl_nxt;
   logic [4:0] msize_r, msize_nxt;
   logic [2:0] mode_r, mode_nxt;
   logic send_r, send_nxt;
   logic mclr_r, mclr_nxt;
   logic [5:0] mcnt_r, mcnt_nxt;
   logic [4:0] head_r, head_nxt;
   logic [4:0] tail_r, tail_nxt;
   logic abort_r, abort_nxt;
   logic larb_r, larb_nxt;
   logic berr_r, berr_nxt;
   logic attempt_r, attempt_nxt;
   logic ovf_r, ovf_nxt;
   logic [4:0] esize_r, esize_nxt;
   logic eclr_r, eclr_nxt;
   logic tsen_r, tsen_nxt;
   logic [3:0] eie_r, eie_nxt;
   logic [5:0] ecnt_r, ecnt_nxt;
   logic eovf_r, eovf_nxt;
   logic [DATA_W-1:0] rdata_nxt;
   logic [DATA_W-1:0] msg_status;
   logic [DATA_W-1:0] evt_status;
   logic [2:0] msg_lvl_flags;
   logic [3:0] evt_flags;
   logic is_tx;
   logic cfg_mode;
   logic tx_outcome;
   logic rd_status;

   // wraps a slot index at the configured depth
   function automatic logic [4:0] slot_inc(input logic [4:0] idx,
      input logic [4:0] code);
      if (idx >= code) begin
         slot_inc = 5'h00;
      end else begin
         slot_inc = idx + 5'h01;
      end
   endfunction

   function automatic logic wr_at(input logic [3:0] off, input logic w,
      input logic [ADDR_W-1:0] a);
      wr_at = w && (a == off);
   endfunction

   assign msg_lvl.depth_code = msize_r;
   assign msg_lvl.count = mcnt_r;
   assign evt_lvl.depth_code = esize_r;
   assign evt_lvl.count = ecnt_r;

   cfdfs_level u_msg_level (
      .lvl (msg_lvl.dec)
   );
   cfdfs_level u_evt_level (
      .lvl (evt_lvl.dec)
   );

   always_comb begin
      is_tx = ctrl_r[B_DIR];
      cfg_mode = (mode_r == MODE_CONFIG);
      tx_outcome = TX_DONE && is_tx;
      rd_status = RD && (ADDR == OFF_MSG_STATUS);
      if (is_tx) begin
         msg_lvl_flags[2] = msg_lvl.empty;
         msg_lvl_flags[1] = msg_lvl.half_down;
         msg_lvl_flags[0] = !msg_lvl.full;
      end else begin
         msg_lvl_flags[2] = msg_lvl.full;
         msg_lvl_flags[1] = msg_lvl.half_up;
         msg_lvl_flags[0] = !msg_lvl.empty;
      end
      // index is head for transmit, fill slot for receive
      msg_status = {3'h0, (is_tx ? head_r : tail_r),
         abort_r, larb_r, berr_r,
         attempt_r && is_tx, ovf_r && !is_tx,
         msg_lvl_flags};
      evt_flags = {eovf_r, evt_lvl.full, evt_lvl.half_up,
         !evt_lvl.empty};
      evt_status = {12'h000, evt_flags};
   end

   // register writes and hardware events
   always_comb begin
      ctrl_nxt = ctrl_r;
      msize_nxt = msize_r;
      mode_nxt = mode_r;
      send_nxt = send_r;
      mclr_nxt = 1'b0;
      mcnt_nxt = mcnt_r;
      head_nxt = head_r;
      tail_nxt = tail_r;
      abort_nxt = abort_r;
      larb_nxt = larb_r;
      berr_nxt = berr_r;
      attempt_nxt = attempt_r;
      ovf_nxt = ovf_r;
      if (wr_at(OFF_MODE, WR, ADDR)) begin
         mode_nxt = WDATA[B_MODE_LO +: 3];
      end
      if (wr_at(OFF_MSG_SIZE, WR, ADDR) && cfg_mode) begin
         msize_nxt = WDATA[B_SIZE_LO +: 5];
      end
      // message fifo level tracking
      if (MSG_PUSH && !msg_lvl.full) begin
         mcnt_nxt = mcnt_nxt + 6'h01;
         tail_nxt = slot_inc(tail_r, msize_r);
      end else if (MSG_PUSH && !is_tx) begin
         ovf_nxt = 1'b1;
      end
      if (MSG_POP && !msg_lvl.empty) begin
         mcnt_nxt = mcnt_nxt - 6'h01;
         head_nxt = slot_inc(head_r, msize_r);
      end
      if (tx_outcome) begin
         abort_nxt = TX_ABORTED;
         larb_nxt = TX_LOST_ARB;
         berr_nxt = TX_BUS_ERR;
         if (mcnt_nxt == 6'h00) begin
            send_nxt = 1'b0;
         end
      end
      // an outcome landing beside a status read or status write clear is kept: the update wins
      if (rd_status && !tx_outcome) begin
         abort_nxt = 1'b0;
      end
      if (wr_at(OFF_MSG_STATUS, WR, ADDR)) begin
         if (!tx_outcome) begin
            abort_nxt = 1'b0;
            larb_nxt = 1'b0;
            berr_nxt = 1'b0;
         end
         if (!WDATA[B_ATTEMPT]) begin
            attempt_nxt = 1'b0;
         end
         if (!WDATA[B_OVF]) begin
            ovf_nxt = 1'b0;
         end
      end
      if (TX_ATTEMPTS_OUT && is_tx) begin
         attempt_nxt = 1'b1;
      end
      if (MSG_PUSH && msg_lvl.full && !is_tx) begin
         ovf_nxt = 1'b1;
      end
      if (wr_at(OFF_MSG_CTRL, WR, ADDR)) begin
         ctrl_nxt = WDATA[7:0];
         if (WDATA[B_SEND] && is_tx) begin
            send_nxt = 1'b1;
            abort_nxt = 1'b0;
            larb_nxt = 1'b0;
            berr_nxt = 1'b0;
         end else if (!WDATA[B_SEND]) begin
            send_nxt = 1'b0;
         end
         if (WDATA[B_ADV] && !mclr_r) begin
            if (is_tx && !msg_lvl.full) begin
               mcnt_nxt = mcnt_r + 6'h01;
               tail_nxt = slot_inc(tail_r, msize_r);
            end else if (!is_tx && !msg_lvl.empty) begin
               mcnt_nxt = mcnt_r - 6'h01;
               head_nxt = slot_inc(head_r, msize_r);
            end
         end
         mclr_nxt = WDATA[B_CLEAR];
      end
      if (mclr_r) begin
         mcnt_nxt = 6'h00;
         head_nxt = 5'h00;
         tail_nxt = 5'h00;
         send_nxt = 1'b0;
         abort_nxt = 1'b0;
         larb_nxt = 1'b0;
         berr_nxt = 1'b0;
      end
   end

   // event fifo level, overflow and control
   always_comb begin
      esize_nxt = esize_r;
      eclr_nxt = 1'b0;
      tsen_nxt = tsen_r;
      eie_nxt = eie_r;
      ecnt_nxt = ecnt_r;
      eovf_nxt = eovf_r;
      if (wr_at(OFF_EVT_CTRL_HIGH, WR, ADDR) && cfg_mode) begin
         esize_nxt = WDATA[B_SIZE_LO +: 5];
      end
      if (EVT_PUSH) begin
         if (evt_lvl.full) begin
            eovf_nxt = 1'b1;
         end else begin
            ecnt_nxt = ecnt_r + 6'h01;
         end
      end
      if (wr_at(OFF_EVT_STATUS, WR, ADDR) && !WDATA[B_OVF]
         && !(EVT_PUSH && evt_lvl.full)) begin
         eovf_nxt = 1'b0;
      end
      if (wr_at(OFF_EVT_CTRL_LOW, WR, ADDR)) begin
         tsen_nxt = WDATA[B_TSEN];
         eie_nxt = WDATA[3:0];
         eclr_nxt = WDATA[B_CLEAR];
         if (WDATA[B_ADV] && !evt_lvl.empty) begin
            ecnt_nxt = ecnt_nxt - 6'h01;
         end
      end
      if (eclr_r) begin
         ecnt_nxt = 6'h00;
         eovf_nxt = 1'b0;
      end
   end

   always_comb begin
      rdata_nxt = '0;
      case (ADDR)
         OFF_MSG_CTRL: begin
            rdata_nxt = {5'h00, mclr_r, send_r, 1'b0, ctrl_r};
         end
         OFF_MSG_STATUS: rdata_nxt = msg_status;
         OFF_MSG_SIZE: rdata_nxt = {3'h0, msize_r, 8'h00};
         OFF_EVT_CTRL_HIGH: rdata_nxt = {3'h0, esize_r, 8'h00};
         OFF_EVT_CTRL_LOW: begin
            rdata_nxt = {5'h00, eclr_r, 4'h0, tsen_r, 1'b0, eie_r};
         end
         OFF_EVT_STATUS: rdata_nxt = evt_status;
         OFF_MODE: rdata_nxt = {13'h0000, mode_r};
         OFF_EVT_LEVEL: rdata_nxt = {10'h000, ecnt_r};
         default: rdata_nxt = '0;
      endcase
      if (!RD) begin
         rdata_nxt = '0;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_r <= MSG_CTRL_RESET;
         msize_r <= SIZE_RESET;
         mode_r <= MODE_RESET;
         send_r <= 1'b0;
         mclr_r <= 1'b0;
         mcnt_r <= 6'h00;
         head_r <= 5'h00;
         tail_r <= 5'h00;
         abort_r <= 1'b0;
         larb_r <= 1'b0;
         berr_r <= 1'b0;
         attempt_r <= 1'b0;
         ovf_r <= 1'b0;
         RDATA <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         msize_r <= msize_nxt;
         mode_r <= mode_nxt;
         send_r <= send_nxt;
         mclr_r <= mclr_nxt;
         mcnt_r <= mcnt_nxt;
         head_r <= head_nxt;
         tail_r <= tail_nxt;
         abort_r <= abort_nxt;
         larb_r <= larb_nxt;
         berr_r <= berr_nxt;
         attempt_r <= attempt_nxt;
         ovf_r <= ovf_nxt;
         RDATA <= rdata_nxt;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         esize_r <= SIZE_RESET;
         eclr_r <= 1'b0;
         tsen_r <= 1'b0;
         eie_r <= EVT_IE_RESET;
         ecnt_r <= 6'h00;
         eovf_r <= 1'b0;
      end else begin
         esize_r <= esize_nxt;
         eclr_r <= eclr_nxt;
         tsen_r <= tsen_nxt;
         eie_r <= eie_nxt;
         ecnt_r <= ecnt_nxt;
         eovf_r <= eovf_nxt;
      end
   end

   always_comb begin
      EVT_STORE_STAMP = tsen_r && EVT_PUSH;
      SEND_REQUEST = send_r;
      // bits 2..0 of control gate the matching level flags
      MSG_IRQ = |(msg_lvl_flags & ctrl_r[2:0])
         || (attempt_r && is_tx && ctrl_r[4])
         || (ovf_r && !is_tx && ctrl_r[3]);
      EVT_IRQ = |(evt_flags & eie_r);
   end
endmodule

// *** cfdfs_top_tb_top.sv ***
// scenario bench for the fifo status and flag block
`timescale 1ns/1ps
module cfdfs_top_tb_top import cfdfs_pkg::*; ;
   logic CLOCK = 1'b0;
   logic RESETN = 1'b0;
   logic [ADDR_W-1:0] ADDR = '0;
   logic [DATA_W-1:0] WDATA = '0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic MSG_PUSH = 1'b0;
   logic MSG_POP = 1'b0;
   logic TX_DONE = 1'b0;
   logic TX_ABORTED = 1'b0;
   logic TX_LOST_ARB = 1'b0;
   logic TX_BUS_ERR = 1'b0;
   logic TX_ATTEMPTS_OUT = 1'b0;
   logic EVT_PUSH = 1'b0;
   logic [DATA_W-1:0] RDATA;
   logic EVT_STORE_STAMP;
   logic SEND_REQUEST;
   logic MSG_IRQ;
   logic EVT_IRQ;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   cfdfs_top i_cfdfs_top (
      .CLOCK (CLOCK),
      .RESETN (RESETN),
      .ADDR (ADDR),
      .WDATA (WDATA),
      .WR (WR),
      .RD (RD),
      .RDATA (RDATA),
      .MSG_PUSH (MSG_PUSH),
      .MSG_POP (MSG_POP),
      .TX_DONE (TX_DONE),
      .TX_ABORTED (TX_ABORTED),
      .TX_LOST_ARB (TX_LOST_ARB),
      .TX_BUS_ERR (TX_BUS_ERR),
      .TX_ATTEMPTS_OUT (TX_ATTEMPTS_OUT),
      .EVT_PUSH (EVT_PUSH),
      .EVT_STORE_STAMP (EVT_STORE_STAMP),
      .SEND_REQUEST (SEND_REQUEST),
      .MSG_IRQ (MSG_IRQ),
      .EVT_IRQ (EVT_IRQ)
   );
   always #4 CLOCK = ~CLOCK;
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch = n_mismatch + 1;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLOCK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge CLOCK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 chk("rdata", e, RDATA);
   endtask
   // push, pop, done, aborted, lost, bus error, attempts
   task automatic eng(input logic [6:0] v);
      @(posedge CLOCK);
      {MSG_PUSH, MSG_POP, TX_DONE, TX_ABORTED, TX_LOST_ARB, TX_BUS_ERR,
         TX_ATTEMPTS_OUT} <= v;
      @(posedge CLOCK);
      {MSG_PUSH, MSG_POP, TX_DONE, TX_ABORTED, TX_LOST_ARB, TX_BUS_ERR,
         TX_ATTEMPTS_OUT} <= 7'h00;
   endtask
   task automatic evt(input logic st);
      @(posedge CLOCK);
      EVT_PUSH <= 1'b1;
      #1 chk("stamp", 16'(st), 16'(EVT_STORE_STAMP));
      @(posedge CLOCK);
      EVT_PUSH <= 1'b0;
   endtask
   task automatic t_reset();
      rd(OFF_MODE, 16'h0004);
      rd(4'h8, 16'h0000);
      rd(OFF_MSG_STATUS, 16'h0000);
      rd(OFF_EVT_STATUS, 16'h0000);
   endtask
   task automatic t_rx();
      wr(OFF_MSG_SIZE, 16'h0300);
      wr(OFF_MSG_CTRL, 16'h0007);
      eng(7'h40);
      eng(7'h40);
      rd(OFF_MSG_STATUS, 16'h0203);
      chk("msg_irq", 16'h0001, 16'(MSG_IRQ));
      eng(7'h40);
      eng(7'h40);
      rd(OFF_MSG_STATUS, 16'h0007);
      eng(7'h40);
      rd(OFF_MSG_STATUS, 16'h000F);
      wr(OFF_MSG_STATUS, 16'h0000);
      rd(OFF_MSG_STATUS, 16'h0007);
   endtask
   task automatic t_tx();
      wr(OFF_MSG_CTRL, 16'h0480);
      repeat (2) @(posedge CLOCK);
      rd(OFF_MSG_STATUS, 16'h0007);
      chk("msg_irq", 16'h0000, 16'(MSG_IRQ));
      repeat (3) eng(7'h40);
      eng(7'h01);
      rd(OFF_MSG_STATUS, 16'h0011);
      eng(7'h1E);
      rd(OFF_MSG_STATUS, 16'h00F1);
      rd(OFF_MSG_STATUS, 16'h0071);
      wr(OFF_MSG_STATUS, 16'h0000);
      rd(OFF_MSG_STATUS, 16'h0001);
      eng(7'h1E);
      wr(OFF_MSG_CTRL, 16'h0280);
      rd(OFF_MSG_STATUS, 16'h0001);
      chk("send", 16'h0001, 16'(SEND_REQUEST));
      wr(OFF_MSG_CTRL, 16'h0281);
      #1 chk("msg_irq", 16'h0001, 16'(MSG_IRQ));
      eng(7'h20);
      rd(OFF_MSG_STATUS, 16'h0103);
   endtask
   task automatic t_evt();
      wr(OFF_EVT_CTRL_HIGH, 16'h0100);
      wr(OFF_EVT_CTRL_LOW, 16'h0021);
      evt(1'b1);
      rd(OFF_EVT_STATUS, 16'h0003);
      chk("evt_irq", 16'h0001, 16'(EVT_IRQ));
      evt(1'b1);
      rd(OFF_EVT_STATUS, 16'h0007);
      evt(1'b1);
      rd(OFF_EVT_STATUS, 16'h000F);
      wr(OFF_EVT_CTRL_LOW, 16'h0121);
      rd(OFF_EVT_STATUS, 16'h000B);
      wr(OFF_EVT_STATUS, 16'h0000);
      rd(OFF_EVT_STATUS, 16'h0003);
      wr(OFF_EVT_CTRL_LOW, 16'h0400);
      repeat (2) @(posedge CLOCK);
      rd(OFF_EVT_STATUS, 16'h0000);
      chk("evt_irq", 16'h0000, 16'(EVT_IRQ));
      evt(1'b0);
      rd(OFF_EVT_LEVEL, 16'h0001);
      wr(OFF_MODE, 16'h0000);
      wr(OFF_EVT_CTRL_HIGH, 16'h1F00);
      rd(OFF_EVT_CTRL_HIGH, 16'h0100);
      wr(OFF_MODE, 16'h0004);
      wr(OFF_EVT_CTRL_HIGH, 16'h1F00);
      rd(OFF_EVT_CTRL_HIGH, 16'h1F00);
   endtask
   initial begin
      repeat (5) @(posedge CLOCK);
      RESETN <= 1'b1;
      t_reset();
      t_rx();
      t_tx();
      t_evt();
      close_out();
   end
endmodule
